// *** design/pmic_pkg.sv ***
package pmic_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_OUT  = 5;
  localparam int NUM_BUCK = 3;
  localparam int NUM_RST  = 3;
  localparam int DLY_W    = 8;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEQ_TICK_NS   = 1000;
  localparam int SEQ_TICK_CYC  = (SEQ_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_MS      = 100;
  localparam int RETRY_CYC     = RETRY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_W        = 8;
  localparam int RETRY_W       = 24;

  // ==========================================================
  // synchroniser bit positions
  localparam int SY_INPUT_UNDERVOLTAGE_THRESHOLD = 0;
  localparam int SY_INPUT_OVERVOLTAGE_THRESHOLD = 1;
  localparam int SY_PEN    = 2;
  localparam int SY_THERM  = 3;
  localparam int SY_OV     = 4;
  localparam int SY_UV     = SY_OV + NUM_OUT;
  localparam int SY_SS     = SY_UV + NUM_OUT;
  localparam int SYNC_W    = SY_SS + NUM_OUT;

  // ==========================================================
  // power states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_SEQ_START,
    ST_ACTIVE,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_THERMAL,
    ST_VFAULT
  } pstate_type;

endpackage : pmic_pkg

// *** design/pmic_power_state_machine.sv ***
`timescale 1ns/1ps
module pmic_power_state_machine
  import pmic_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  // analog monitor pins
  input  wire logic                          vin_above_uv,
  input  wire logic                          vin_below_ov,
  input  wire logic                          thermal_trip,
  input  wire logic [NUM_OUT-1:0]            reg_ov,
  input  wire logic [NUM_OUT-1:0]            reg_uv,
  input  wire logic [NUM_OUT-1:0]            softstart_done,
  // host pin
  input  wire logic                          power_enable_pin,
  // control bits from register file
  input  wire logic                          sleep_request_bit,
  input  wire logic                          sleep_permit_bit,
  input  wire logic                          deep_sleep_request_bit,
  input  wire logic                          deep_sleep_select,
  input  wire logic                          voltage_fault_halt_disable,
  input  wire logic                          thermal_interrupt_mask,
  input  wire logic [NUM_OUT-1:0]            ov_mask,
  input  wire logic [NUM_OUT-1:0]            uv_mask,
  input  wire logic [NUM_OUT-1:0]            sleep_out_on,
  input  wire logic [NUM_BUCK-1:0]           sleep_buck_alt,
  input  wire logic [NUM_OUT-1:0]            deep_out_on,
  input  wire logic [NUM_OUT-1:0][DLY_W-1:0] seq_delay,
  input  wire logic                          arm_write,
  input  wire logic                          arm_write_data,
  // regulator and reset outputs
  output logic [NUM_OUT-1:0]                 reg_enable,
  output logic [NUM_BUCK-1:0]                buck_use_alternate,
  output logic [NUM_RST-1:0]                 reset_out_n,
  output logic                               interrupt_line_low,
  // status to register file
  output logic                               regs_to_default,
  output logic                               i2c_engine_reset,
  output logic                               deep_sleep_arm_bit,
  output pstate_type                         power_state,
  output logic [NUM_OUT-1:0]                 ov_status,
  output logic [NUM_OUT-1:0]                 uv_status
);

  // ==========================================================
  // input synchronisers
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] pins_raw;
  assign pins_raw = {softstart_done, reg_uv, reg_ov, thermal_trip,
                     power_enable_pin, vin_below_ov, vin_above_uv};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  logic               uv_ok;
  logic               ov_ok;
  logic               pen;
  logic               therm;
  logic [NUM_OUT-1:0] ov_s;
  logic [NUM_OUT-1:0] uv_s;
  logic [NUM_OUT-1:0] ss_s;
  assign uv_ok = sync2_q[SY_INPUT_UNDERVOLTAGE_THRESHOLD];
  assign ov_ok = sync2_q[SY_INPUT_OVERVOLTAGE_THRESHOLD];
  assign pen   = sync2_q[SY_PEN];
  assign therm = sync2_q[SY_THERM];
  assign ov_s  = sync2_q[SY_OV +: NUM_OUT];
  assign uv_s  = sync2_q[SY_UV +: NUM_OUT];
  assign ss_s  = sync2_q[SY_SS +: NUM_OUT];

  // ==========================================================
  // entry conditions
  pstate_type st_q;
  pstate_type st_d;
  logic       arm_q;
  logic       pen_prev_q;
  logic       pen_rise;
  logic       vfault;
  logic       sleep_cond;
  logic       deep_cond;
  logic       hard_off;
  logic       settled;
  logic       retry_done;
  logic [RETRY_W-1:0] retry_cnt_q;

  // overcurrent is not an input here: it only counts via the undervoltage it causes
  assign vfault = !voltage_fault_halt_disable & ((|ov_s) | (|(uv_s & ss_s)));
  assign sleep_cond = sleep_request_bit & sleep_permit_bit;
  assign deep_cond = !pen & arm_q & (deep_sleep_select | deep_sleep_request_bit);
  assign hard_off = (st_q == ST_RESET) || (st_q == ST_THERMAL) || (st_q == ST_VFAULT);
  assign retry_done = (retry_cnt_q == RETRY_W'(RETRY_CYCLES - 1));
  assign pen_rise = pen & !pen_prev_q;

  // ==========================================================
  // state transitions
  always_comb begin
    st_d = st_q;
    if (!uv_ok) begin
      st_d = ST_RESET;
    end else begin
      case (st_q)
        ST_RESET: begin
          if (ov_ok) begin
            st_d = ST_SEQ_START;
          end
        end
        ST_THERMAL: begin
          if (!therm) begin
            st_d = ST_SEQ_START;
          end
        end
        ST_VFAULT: begin
          if (therm) begin
            st_d = ST_THERMAL;
          end else if (retry_done) begin
            st_d = ST_ACTIVE;
          end
        end
        ST_SEQ_START, ST_ACTIVE, ST_SLEEP, ST_DEEP_SLEEP: begin
          if (st_q == ST_DEEP_SLEEP && (therm || vfault)) begin
            st_d = ST_ACTIVE;
          end else if (therm) begin
            st_d = ST_THERMAL;
          end else if (vfault) begin
            st_d = ST_VFAULT;
          end else if (st_q == ST_SEQ_START && !settled) begin
            st_d = ST_SEQ_START;
          end else if (deep_cond) begin
            st_d = ST_DEEP_SLEEP;
          end else if (sleep_cond) begin
            st_d = ST_SLEEP;
          end else begin
            st_d = ST_ACTIVE;
          end
        end
        default: st_d = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // voltage fault retry timer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      retry_cnt_q <= '0;
    end else if (st_q != ST_VFAULT || retry_done) begin
      retry_cnt_q <= '0;
    end else begin
      retry_cnt_q <= retry_cnt_q + RETRY_W'(1);
    end
  end

  // ==========================================================
  // deep sleep arm bit
  // pen_prev held high in reset so a pin already high at power-up is no edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pen_prev_q <= 1'b1;
    end else if (st_q == ST_RESET) begin
      pen_prev_q <= 1'b1;
    end else begin
      pen_prev_q <= pen;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_q <= 1'b0;
    end else if (st_q == ST_RESET) begin
      arm_q <= 1'b0;
    end else if (pen_rise) begin
      arm_q <= 1'b1;
    end else if (st_q == ST_DEEP_SLEEP && (therm || vfault)) begin
      arm_q <= 1'b0;
    end else if (arm_write) begin
      arm_q <= arm_write_data;
    end
  end

  // ==========================================================
  // per-output sequencing
  logic [TICK_W-1:0]  tick_cnt_q;
  logic               tick;
  logic [NUM_OUT-1:0] target;
  logic [NUM_OUT-1:0] en_q;
  assign tick = (tick_cnt_q == TICK_W'(SEQ_TICK_CYC - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end
  always_comb begin
    case (st_q)
      ST_SLEEP:      target = sleep_out_on;
      ST_DEEP_SLEEP: target = deep_out_on;
      ST_SEQ_START:  target = '1;
      ST_ACTIVE:     target = '1;
      default:       target = '0;
    endcase
  end
  assign settled = (en_q == target);
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      logic [DLY_W-1:0] dly_q;
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          en_q[gi] <= 1'b0;
          dly_q    <= '0;
        end else if (hard_off) begin
          en_q[gi] <= 1'b0;
          dly_q    <= '0;
        end else if (en_q[gi] == target[gi]) begin
          dly_q <= '0;
        end else if (tick) begin
          if (dly_q >= seq_delay[gi]) begin
            en_q[gi] <= target[gi];
            dly_q    <= '0;
          end else begin
            dly_q <= dly_q + DLY_W'(1);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // output registers
  logic [NUM_BUCK-1:0] alt_q;
  logic [NUM_RST-1:0]  rst_n_q;
  logic                irq_n_q;
  logic                dflt_q;
  logic                i2c_rst_q;
  logic [NUM_OUT-1:0]  ov_stat_q;
  logic [NUM_OUT-1:0]  uv_stat_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alt_q <= '0;
    end else if (st_q == ST_SLEEP) begin
      alt_q <= sleep_buck_alt;
    end else begin
      alt_q <= '0;
    end
  end

  // reset outputs stay low through sequence start; released only in run states, also while a retry ramps in active
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_n_q <= '0;
    end else if (hard_off || st_q == ST_SEQ_START) begin
      rst_n_q <= '0;
    end else begin
      rst_n_q <= '1;
    end
  end

  // masks hide only the interrupt; state and status ignore them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !((therm & !thermal_interrupt_mask) | (|(ov_s & ~ov_mask)) | (|(uv_s & ~uv_mask)));
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ov_stat_q <= '0;
      uv_stat_q <= '0;
    end else begin
      ov_stat_q <= ov_s;
      uv_stat_q <= uv_s;
    end
  end

  // register file is only cleared in reset; sleep states keep it live
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dflt_q    <= 1'b1;
      i2c_rst_q <= 1'b0;
    end else begin
      dflt_q    <= (st_d == ST_RESET);
      i2c_rst_q <= (st_d != st_q) && (st_d == ST_DEEP_SLEEP || st_d == ST_VFAULT || st_d == ST_THERMAL);
    end
  end

  assign reg_enable         = en_q;
  assign buck_use_alternate = alt_q;
  assign reset_out_n        = rst_n_q;
  assign interrupt_line_low = irq_n_q;
  assign regs_to_default    = dflt_q;
  assign i2c_engine_reset   = i2c_rst_q;
  assign deep_sleep_arm_bit = arm_q;
  assign power_state        = st_q;
  assign ov_status          = ov_stat_q;
  assign uv_status          = uv_stat_q;

  // ==========================================================
  // assertions
  sequence s_enter_quiet;
    (st_q != ST_DEEP_SLEEP && st_q != ST_VFAULT && st_q != ST_THERMAL)
    ##1 (st_q == ST_DEEP_SLEEP || st_q == ST_VFAULT || st_q == ST_THERMAL);
  endsequence
  // a pin rise in the same cycle re-arms, so it is left out here
  sequence s_deep_fault;
    (st_q == ST_DEEP_SLEEP && uv_ok && !pen_rise && (therm || vfault));
  endsequence
  AST_RESET_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_RESET) |=> (reg_enable == '0 && reset_out_n == '0))
    else $error("outputs active in reset state");
  AST_LEAVE_RESET: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_RESET && uv_ok && ov_ok) |=> (st_q == ST_SEQ_START))
    else $error("valid input did not leave reset");
  AST_UV_RESET: assert property (@(posedge mclk) disable iff (!nrst)
    (!uv_ok) |=> (st_q == ST_RESET && regs_to_default))
    else $error("undervoltage did not return to reset");
  AST_SEQ_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_SEQ_START) |=> (reset_out_n == '0))
    else $error("reset outputs released during sequence start");
  AST_SLEEP_EXIT: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_SLEEP && !sleep_cond) |=> (st_q != ST_SLEEP))
    else $error("sleep held without request and permit");
  AST_DEEP_ENTER: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_ACTIVE && uv_ok && !therm && !vfault && deep_cond) |=> (st_q == ST_DEEP_SLEEP))
    else $error("deep sleep condition ignored");
  AST_ARM_RISE: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q != ST_RESET && pen_rise) |=> arm_q)
    else $error("pin rise did not arm deep sleep");
  AST_FAULT_DISARM: assert property (@(posedge mclk) disable iff (!nrst)
    s_deep_fault |=> (!arm_q && st_q == ST_ACTIVE) ##1 (st_q != ST_DEEP_SLEEP))
    else $error("fault exit from deep sleep mishandled");
  AST_THERMAL: assert property (@(posedge mclk) disable iff (!nrst)
    (uv_ok && therm && (st_q == ST_ACTIVE || st_q == ST_SLEEP)) |=> (st_q == ST_THERMAL) ##1 (reg_enable == '0))
    else $error("over temperature did not shut down");
  AST_RETRY: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_VFAULT && retry_done && uv_ok && !therm) |=> (st_q == ST_ACTIVE))
    else $error("voltage fault retry missed");
  AST_HALT_DIS: assert property (@(posedge mclk) disable iff (!nrst)
    (voltage_fault_halt_disable && st_q == ST_ACTIVE) |=> (st_q != ST_VFAULT))
    else $error("voltage fault entered while disabled");
  AST_I2C_RESET: assert property (@(posedge mclk) disable iff (!nrst)
    s_enter_quiet |-> i2c_engine_reset)
    else $error("packet engine not reset on entry");

endmodule : pmic_power_state_machine

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// host side: power enable pin and control bits
module host_model (
  // clock
  input  wire logic mclk,
  // pin and control bits
  output logic      power_enable_pin,
  output logic      sleep_request_bit,
  output logic      sleep_permit_bit,
  output logic      deep_sleep_request_bit,
  output logic      deep_sleep_select,
  output logic      arm_write,
  output logic      arm_write_data
);
  // pin already high at power-up, the awkward board case
  initial begin
    power_enable_pin       = 1'b1;
    sleep_request_bit      = 1'b0;
    sleep_permit_bit       = 1'b0;
    deep_sleep_request_bit = 1'b0;
    deep_sleep_select      = 1'b0;
    arm_write              = 1'b0;
    arm_write_data         = 1'b0;
  end

  task automatic set_pin(input logic v);
    @(posedge mclk);
    power_enable_pin <= v;
  endtask : set_pin

  // low then high again, spaced past the pin syncer
  task automatic arm_from_high();
    set_pin(1'b0);
    repeat (6) @(posedge mclk);
    set_pin(1'b1);
    repeat (6) @(posedge mclk);
  endtask : arm_from_high

  task automatic set_sleep(input logic req, input logic permit);
    @(posedge mclk);
    sleep_request_bit <= req;
    sleep_permit_bit  <= permit;
  endtask : set_sleep

  task automatic set_deep(input logic req, input logic sel);
    @(posedge mclk);
    deep_sleep_request_bit <= req;
    deep_sleep_select      <= sel;
  endtask : set_deep

  task automatic write_arm(input logic v);
    @(posedge mclk);
    arm_write      <= 1'b1;
    arm_write_data <= v;
    @(posedge mclk);
    arm_write      <= 1'b0;
  endtask : write_arm
endmodule : host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pmic_pkg::*;
  // shortened retry so the fault loop fits the run
  localparam int RETRY = 20;

  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic vin_above_uv = 1'b0, vin_below_ov = 1'b1, thermal_trip = 1'b0;
  logic [NUM_OUT-1:0] reg_ov = '0, reg_uv = '0, softstart_done = '1;
  logic [NUM_OUT-1:0] ov_mask = '0, uv_mask = '0, sleep_out_on = 5'h0a, deep_out_on = 5'h01;
  logic [NUM_BUCK-1:0] sleep_buck_alt = 3'h2;
  logic [NUM_OUT-1:0][DLY_W-1:0] seq_delay = {8'h02, 8'h03, 8'h04, 8'h02, 8'h03};
  logic halt_dis = 1'b0, tmask = 1'b0;
  logic pen, s_req, s_perm, d_req, d_sel, a_wr, a_wd;
  logic [NUM_OUT-1:0] reg_enable, ov_status, uv_status;
  logic [NUM_BUCK-1:0] buck_use_alternate;
  logic [NUM_RST-1:0] reset_out_n;
  logic interrupt_line_low, regs_to_default, i2c_engine_reset, deep_sleep_arm_bit;
  pstate_type power_state;
  int errors = 0;
  int num_checks = 0;

  always #4 mclk = ~mclk;

  host_model host (.mclk(mclk), .power_enable_pin(pen), .sleep_request_bit(s_req),
    .sleep_permit_bit(s_perm), .deep_sleep_request_bit(d_req), .deep_sleep_select(d_sel),
    .arm_write(a_wr), .arm_write_data(a_wd));

  pmic_power_state_machine #(.RETRY_CYCLES(RETRY)) dut (
    .mclk(mclk), .nrst(nrst), .vin_above_uv(vin_above_uv), .vin_below_ov(vin_below_ov),
    .thermal_trip(thermal_trip), .reg_ov(reg_ov), .reg_uv(reg_uv), .softstart_done(softstart_done),
    .power_enable_pin(pen), .sleep_request_bit(s_req), .sleep_permit_bit(s_perm),
    .deep_sleep_request_bit(d_req), .deep_sleep_select(d_sel), .voltage_fault_halt_disable(halt_dis),
    .thermal_interrupt_mask(tmask), .ov_mask(ov_mask), .uv_mask(uv_mask), .sleep_out_on(sleep_out_on),
    .sleep_buck_alt(sleep_buck_alt), .deep_out_on(deep_out_on), .seq_delay(seq_delay),
    .arm_write(a_wr), .arm_write_data(a_wd), .reg_enable(reg_enable),
    .buck_use_alternate(buck_use_alternate), .reset_out_n(reset_out_n),
    .interrupt_line_low(interrupt_line_low), .regs_to_default(regs_to_default),
    .i2c_engine_reset(i2c_engine_reset), .deep_sleep_arm_bit(deep_sleep_arm_bit),
    .power_state(power_state), .ov_status(ov_status), .uv_status(uv_status));

  // ==========================================================
  // compare and wait helpers
  task automatic chk_state(input pstate_type got, input pstate_type exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t state %0d expected %0d", $time, got, exp);
    end
  endtask : chk_state

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // samples every cycle so a one-cycle pulse at entry can be seen
  task automatic wait_state(input pstate_type s, input int lim);
    int i;
    i = 0;
    while (power_state !== s && i < lim) begin
      cyc(1);
      i++;
    end
    chk_state(power_state, s);
  endtask : wait_state

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // scenarios
  task automatic t_power_up();
    cyc(6);
    chk_state(power_state, ST_RESET);
    chk_vec({3'h0, reg_enable}, 8'h00);
    chk_vec({5'h0, reset_out_n}, 8'h00);
    chk_vec({7'h0, regs_to_default}, 8'h01);
    @(posedge mclk);
    vin_above_uv <= 1'b1;
    wait_state(ST_SEQ_START, 8);
    chk_vec({5'h0, reset_out_n}, 8'h00);
    wait_state(ST_ACTIVE, 2000);
    cyc(2);
    chk_vec({3'h0, reg_enable}, 8'h1f);
    chk_vec({5'h0, reset_out_n}, 8'h07);
    chk_vec({7'h0, deep_sleep_arm_bit}, 8'h00);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_sleep();
    host.set_sleep(1'b1, 1'b0);
    cyc(8);
    chk_state(power_state, ST_ACTIVE);
    host.set_sleep(1'b1, 1'b1);
    wait_state(ST_SLEEP, 8);
    cyc(10);
    chk_vec({3'h0, reg_enable}, 8'h1f);
    cyc(1000);
    chk_vec({3'h0, reg_enable}, {3'h0, sleep_out_on});
    chk_vec({5'h0, buck_use_alternate}, 8'h02);
    chk_vec({7'h0, regs_to_default}, 8'h00);
    host.set_sleep(1'b1, 1'b0);
    wait_state(ST_ACTIVE, 4);
    cyc(1000);
    chk_vec({3'h0, reg_enable}, 8'h1f);
    host.set_sleep(1'b0, 1'b0);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_deep();
    host.arm_from_high();
    chk_vec({7'h0, deep_sleep_arm_bit}, 8'h01);
    host.set_deep(1'b0, 1'b1);
    host.set_pin(1'b0);
    wait_state(ST_DEEP_SLEEP, 8);
    chk_vec({7'h0, i2c_engine_reset}, 8'h01);
    cyc(10);
    chk_vec({3'h0, reg_enable}, 8'h1f);
    cyc(1000);
    chk_vec({3'h0, reg_enable}, {3'h0, deep_out_on});
    host.set_pin(1'b1);
    wait_state(ST_ACTIVE, 2000);
    host.set_deep(1'b0, 1'b0);
    host.set_pin(1'b0);
    cyc(10);
    chk_state(power_state, ST_ACTIVE);
    host.set_deep(1'b1, 1'b0);
    wait_state(ST_DEEP_SLEEP, 8);
    $display("test deep_sleep done");
  endtask : t_deep

  task automatic t_deep_fault();
    @(posedge mclk);
    tmask        <= 1'b1;
    thermal_trip <= 1'b1;
    wait_state(ST_ACTIVE, 8);
    chk_vec({7'h0, deep_sleep_arm_bit}, 8'h00);
    wait_state(ST_THERMAL, 8);
    chk_vec({7'h0, i2c_engine_reset}, 8'h01);
    cyc(2);
    chk_vec({3'h0, reg_enable}, 8'h00);
    chk_vec({5'h0, reset_out_n}, 8'h00);
    chk_vec({7'h0, interrupt_line_low}, 8'h01);
    @(posedge mclk);
    thermal_trip <= 1'b0;
    wait_state(ST_ACTIVE, 2000);
    cyc(10);
    chk_state(power_state, ST_ACTIVE);
    host.write_arm(1'b1);
    wait_state(ST_DEEP_SLEEP, 8);
    host.set_deep(1'b0, 1'b0);
    host.set_pin(1'b1);
    wait_state(ST_ACTIVE, 2000);
    $display("test deep_fault done");
  endtask : t_deep_fault

  task automatic t_vfault();
    int n;
    @(posedge mclk);
    ov_mask <= 5'h1f;
    reg_ov  <= 5'h02;
    wait_state(ST_VFAULT, 8);
    n = 1;
    chk_vec({3'h0, ov_status}, 8'h02);
    chk_vec({7'h0, interrupt_line_low}, 8'h01);
    cyc(1);
    n++;
    chk_vec({3'h0, reg_enable}, 8'h00);
    chk_vec({5'h0, reset_out_n}, 8'h00);
    while (power_state === ST_VFAULT && n < 3 * RETRY) begin
      cyc(1);
      n++;
    end
    chk_vec({7'h0, n >= RETRY - 1 && n <= RETRY + 1}, 8'h01);
    wait_state(ST_VFAULT, 8);
    @(posedge mclk);
    thermal_trip <= 1'b1;
    wait_state(ST_THERMAL, 3 * RETRY);
    @(posedge mclk);
    thermal_trip <= 1'b0;
    reg_ov       <= 5'h00;
    wait_state(ST_ACTIVE, 2000);
    @(posedge mclk);
    softstart_done <= 5'h1b;
    reg_uv         <= 5'h04;
    cyc(10);
    chk_state(power_state, ST_ACTIVE);
    chk_vec({3'h0, uv_status}, 8'h04);
    chk_vec({7'h0, interrupt_line_low}, 8'h00);
    @(posedge mclk);
    halt_dis <= 1'b1;
    reg_ov   <= 5'h01;
    cyc(10);
    chk_state(power_state, ST_ACTIVE);
    chk_vec({3'h0, ov_status}, 8'h01);
    // faults drain through the syncer before the halt is re-enabled
    @(posedge mclk);
    reg_ov         <= 5'h00;
    reg_uv         <= 5'h00;
    softstart_done <= 5'h1f;
    cyc(4);
    @(posedge mclk);
    halt_dis       <= 1'b0;
    cyc(4);
    chk_state(power_state, ST_ACTIVE);
    $display("test vfault done");
  endtask : t_vfault

  task automatic t_vin_drop();
    host.set_sleep(1'b1, 1'b1);
    @(posedge mclk);
    vin_above_uv <= 1'b0;
    wait_state(ST_RESET, 8);
    chk_vec({7'h0, regs_to_default}, 8'h01);
    @(posedge mclk);
    vin_above_uv <= 1'b1;
    wait_state(ST_SEQ_START, 8);
    wait_state(ST_SLEEP, 2000);
    $display("test vin_drop done");
  endtask : t_vin_drop

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_power_up();
    t_sleep();
    t_deep();
    t_deep_fault();
    t_vfault();
    t_vin_drop();
    close_out();
  end

  // roughly ten times the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule : tb
